/* inc/tariff_pkg.sv */
package tariff_pkg;

  // Table sizes
  localparam int EXC_N  = 50;
  localparam int SEAS_N = 4;
  localparam int WEEK_N = 4;
  localparam int DAYT_N = 8;
  localparam int DENT_N = 8;

  // Register byte addresses
  localparam logic [11:0] A_STATUS    = 12'h000;
  localparam logic [11:0] A_LIMIT     = 12'h004;
  localparam logic [11:0] A_IRQ_STAT  = 12'h008;
  localparam logic [11:0] A_IRQ_CLR   = 12'h00C;
  localparam logic [11:0] A_IRQ_EN    = 12'h010;
  localparam logic [11:0] A_ACT_DATE  = 12'h014;
  localparam logic [11:0] A_ACT_TIME  = 12'h018;
  localparam logic [11:0] A_EXC_CNT   = 12'h01C;
  localparam logic [11:0] A_FAULT_CLR = 12'h020;
  // Table regions: exception list, then two calendars
  localparam logic [3:0]  A_EXC_PAGE  = 4'h1;
  localparam logic [1:0]  A_CAL_PAGE  = 2'h1;
  localparam logic [1:0]  A_SEAS_SUB  = 2'h0;
  localparam logic [1:0]  A_WEEK_SUB  = 2'h1;

  // Reset values
  localparam logic [15:0] LIMIT_RST = 16'h003C;  // 60 s

  // Event bits of the interrupt status register
  localparam int EV_N       = 4;
  localparam int EV_ACT     = 0;
  localparam int EV_INVALID = 1;
  localparam int EV_LIMIT   = 2;
  localparam int EV_TARIFF  = 3;

  // Status register bit positions
  localparam int ST_TARIFF = 0;
  localparam int ST_FAULT  = 3;
  localparam int ST_PEND   = 4;
  localparam int ST_BANK   = 5;
  localparam int ST_BUSY   = 6;

  typedef struct packed {
    logic       pub;
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] dayid;
  } exc_ent_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] month;
    logic [4:0] day;
    logic [1:0] weekid;
  } seas_ent_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [1:0] tcode;
  } dent_s;

  // Days since 1 Jan 2000
  function automatic logic [16:0] days_since(input logic [6:0] y,
                                             input logic [3:0] m,
                                             input logic [4:0] d);
    logic [16:0] cum;
    logic [16:0] yy;
    yy = {10'h000, y};
    case (m)
      4'h2:    cum = 17'h0001F;
      4'h3:    cum = 17'h0003B;
      4'h4:    cum = 17'h0005A;
      4'h5:    cum = 17'h00078;
      4'h6:    cum = 17'h00097;
      4'h7:    cum = 17'h000B5;
      4'h8:    cum = 17'h000D4;
      4'h9:    cum = 17'h000F3;
      4'hA:    cum = 17'h00111;
      4'hB:    cum = 17'h00130;
      4'hC:    cum = 17'h0014E;
      default: cum = 17'h00000;
    endcase
    if (y[1:0] == 2'h0 && m > 4'h2) begin
      cum = cum + 17'h00001;
    end
    days_since = 17'(yy * 17'h0016D) + 17'((yy + 17'h00003) >> 2)
               + cum + {12'h000, d} - 17'h00001;
  endfunction

  // Seconds since 2000, standard time
  function automatic logic [31:0] secs_of(input logic [6:0] y,
                                          input logic [3:0] m,
                                          input logic [4:0] d,
                                          input logic [4:0] h,
                                          input logic [5:0] mi,
                                          input logic [5:0] s);
    secs_of = 32'(32'(days_since(y, m, d)) * 32'h0001_5180)
            + 32'({27'h0, h} * 32'h0000_0E10)
            + 32'({26'h0, mi} * 32'h0000_003C) + {26'h0, s};
  endfunction

endpackage

/* rtl/clock_set_check.sv */
`timescale 1ns/10ps
`default_nettype none
module clock_set_check (
  input  wire logic        mclk,      // System clock
  input  wire logic        resetn,    // Sync reset, low
  input  wire logic        set_stb,   // Clock-set request
  input  wire logic [31:0] set_secs,  // Requested time, seconds
  input  wire logic [31:0] now_secs,  // Current time, seconds
  input  wire logic [15:0] limit,     // Allowed step, seconds
  output logic             bad        // Step too large, pulse
);
  import tariff_pkg::*;

  typedef struct packed {
    logic bad;
  } chk_s;

  chk_s        chk_r;
  chk_s        chk_nxt;
  logic [31:0] diff;

  // Absolute step between requested and current time
  always_comb begin
    diff = (set_secs >= now_secs) ? set_secs - now_secs
                                  : now_secs - set_secs;
    chk_nxt = chk_r;
    chk_nxt.bad = set_stb && (diff > {16'h0000, limit});  // RULE1
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chk_r <= '0;
    end else begin
      chk_r <= chk_nxt;
    end
  end

  assign bad = chk_r.bad;
endmodule
`default_nettype wire

/* rtl/event_irq.sv */
`timescale 1ns/10ps
`default_nettype none
module event_irq (
  input  wire logic            mclk,    // System clock
  input  wire logic            resetn,  // Sync reset, low
  input  wire logic [3:0]      ev,      // Event pulses
  input  wire logic            clr_we,  // Clear register write
  input  wire logic            en_we,   // Enable register write
  input  wire logic [3:0]      wdata,   // Write data
  output logic      [3:0]      stat,    // Sticky status
  output logic      [3:0]      en,      // Enable mask
  output logic                 irq      // Level interrupt
);
  import tariff_pkg::*;

  typedef struct packed {
    logic [3:0] stat;
    logic [3:0] en;
  } irq_s;

  irq_s irq_r;
  irq_s irq_nxt;

  // New events win over a clear in the same cycle
  always_comb begin
    irq_nxt = irq_r;
    if (clr_we) begin
      irq_nxt.stat = irq_r.stat & ~wdata;
    end
    irq_nxt.stat = irq_nxt.stat | ev;
    if (en_we) begin
      irq_nxt.en = wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign stat = irq_r.stat;
  assign en   = irq_r.en;
  assign irq  = |(irq_r.stat & irq_r.en);
endmodule
`default_nettype wire

/* rtl/tariff_calendar_selector.sv */
// Contract
// RULE1 - Clock set over limit (default 60 s): fault, invalid and limit flags
// RULE2 - Exception list checked first; a match gives the day table directly
// RULE3 - Appointed exceptions match year too; public ones match every year
// RULE4 - Up to fifty exceptions, each with index, date and day table
// RULE5 - Season holds start date and week table; latest earlier start wins
// RULE6 - Up to four seasons; match yields week table for next stage
// RULE7 - Week table maps Monday to Sunday to a day table; four tables
// RULE8 - Day entry pairs hour and minute with tariff one to four
// RULE9 - Up to eight day tables of eight switching entries each
// RULE10 - Passive calendar becomes active when its activation time is reached
// RULE11 - Activation time already past activates right after the write
// RULE12 - Activation time passed during power loss activates on restore; reset here clears pend, so it never fires
// RULE13 - Activation keeps old calendar and time, clears pending mark
// RULE14 - Each activation sends one record to the event log
// RULE15 - Client writes calendars from name, exceptions from count, fully; cfg_client writes no name and only week table 0 and day table 2
// RULE16 - Client writes activation time only after all passive parameters
// RULE17 - Time inputs are years 2000-2099 and usual calendar ranges
// RULE18 - Latest switching time not after now wins; re-evaluated every tick
`timescale 1ns/10ps
`default_nettype none
module tariff_calendar_selector (
  input  wire logic        mclk,       // System clock, 125 MHz
  input  wire logic        resetn,     // Sync reset, low
  input  wire logic [11:0] addr,       // Register byte address
  input  wire logic [31:0] wdata,      // Write data
  input  wire logic        wr_stb,     // Write strobe
  input  wire logic        rd_stb,     // Read strobe
  output logic      [31:0] rdata,      // Read data, cycle after strobe
  input  wire logic        tick_1s,    // One-second tick
  input  wire logic [6:0]  now_year,   // Years after 2000
  input  wire logic [3:0]  now_month,  // 1..12
  input  wire logic [4:0]  now_day,    // 1..31
  input  wire logic [2:0]  now_wday,   // 1 = Monday .. 7
  input  wire logic [4:0]  now_hour,   // 0..23
  input  wire logic [5:0]  now_min,    // 0..59
  input  wire logic [5:0]  now_sec,    // 0..59
  input  wire logic        set_stb,    // Clock-set request
  input  wire logic [6:0]  set_year,   // Requested year
  input  wire logic [3:0]  set_month,  // Requested month
  input  wire logic [4:0]  set_day,    // Requested day
  input  wire logic [4:0]  set_hour,   // Requested hour
  input  wire logic [5:0]  set_min,    // Requested minute
  input  wire logic [5:0]  set_sec,    // Requested second
  output logic      [2:0]  tariff,     // Active tariff 1..4
  output logic             clock_fault,// Clock marked faulty
  output logic             act_event,  // Activation log pulse
  output logic             irq         // Interrupt level
);
  import tariff_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_EXC, S_SEAS, S_DAY} fsm_e;

  typedef struct packed {
    exc_ent_s [EXC_N-1:0]                    exc;
    logic [5:0]                              exc_cnt;
    seas_ent_s [1:0][SEAS_N-1:0]             seas;
    logic [1:0][WEEK_N*8-1:0][2:0]           week;
    dent_s [1:0][DAYT_N*DENT_N-1:0]          dayt;
    logic                                    bank;
    logic                                    pend;
    logic [15:0]                             act_date;
    logic [16:0]                             act_time;
    logic [15:0]                             limit;
    logic                                    fault;
    fsm_e                                    fsm;
    logic [5:0]                              idx;
    logic [2:0]                              dayid;
    logic                                    le_ok;
    logic [10:0]                             le_key;
    logic [2:0]                              le_val;
    logic                                    mx_ok;
    logic [10:0]                             mx_key;
    logic [2:0]                              mx_val;
    logic [2:0]                              tariff;
    logic                                    act_pulse;
    logic                                    tar_chg;
    logic [31:0]                             rdata;
  } st_s;

  st_s         st_r;
  st_s         st_nxt;
  logic        chk_bad;
  logic [3:0]  ev;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_en;
  logic        irq_clr_we;
  logic        irq_en_we;

  // Entry is a better candidate than the one held so far
  function automatic logic takes(input logic ok, input logic [10:0] cur,
                                 input logic [10:0] key);
    takes = !ok || key >= cur;
  endfunction

  // Physical bank behind a logical calendar (0 main, 1 passive)
  function automatic logic phys(input logic bank, input logic passive);
    phys = bank ^ passive;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Clock-set check and interrupt status

  clock_set_check u_chk (
    .mclk     (mclk),
    .resetn   (resetn),
    .set_stb  (set_stb),
    .set_secs (secs_of(set_year, set_month, set_day,
                       set_hour, set_min, set_sec)),
    .now_secs (secs_of(now_year, now_month, now_day,
                       now_hour, now_min, now_sec)),
    .limit    (st_r.limit),
    .bad      (chk_bad)
  );

  // Events raise sticky status bits
  always_comb begin
    ev = '0;
    ev[EV_ACT]     = st_r.act_pulse;
    ev[EV_INVALID] = chk_bad;  // RULE1
    ev[EV_LIMIT]   = chk_bad;  // RULE1
    ev[EV_TARIFF]  = st_r.tar_chg;
  end

  assign irq_clr_we = wr_stb && addr == A_IRQ_CLR;
  assign irq_en_we  = wr_stb && addr == A_IRQ_EN;

  event_irq u_irq (
    .mclk   (mclk),
    .resetn (resetn),
    .ev     (ev),
    .clr_we (irq_clr_we),
    .en_we  (irq_en_we),
    .wdata  (wdata[3:0]),
    .stat   (irq_stat),
    .en     (irq_en),
    .irq    (irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic        pb;
    logic [10:0] key;
    logic [10:0] now_md;
    logic [10:0] now_hm;
    logic [32:0] now_key;
    logic [2:0]  pick;
    exc_ent_s    ex;
    seas_ent_s   se;
    dent_s       de;
    pb      = phys(st_r.bank, addr[9]);
    key     = '0;
    now_md  = {2'h0, now_month, now_day};  // RULE17
    now_hm  = {now_hour, now_min};
    now_key = {now_year, now_month, now_day, now_hour, now_min, now_sec};
    pick    = '0;
    ex      = st_r.exc[st_r.idx];
    se      = st_r.seas[st_r.bank][st_r.idx[1:0]];
    de      = st_r.dayt[st_r.bank][{st_r.dayid, st_r.idx[2:0]}];
    st_nxt  = st_r;
    st_nxt.act_pulse = 1'b0;
    st_nxt.tar_chg   = 1'b0;

    // Register writes; tables accept any order the client uses
    if (wr_stb) begin
      if (addr == A_LIMIT) begin
        st_nxt.limit = wdata[15:0];
      end else if (addr == A_ACT_DATE) begin
        st_nxt.act_date = wdata[15:0];
      end else if (addr == A_ACT_TIME) begin
        // Time goes last, so it arms the passive calendar
        st_nxt.act_time = wdata[16:0];  // RULE16
        st_nxt.pend     = 1'b1;
      end else if (addr == A_EXC_CNT) begin
        st_nxt.exc_cnt = (wdata[5:0] > 6'(EXC_N)) ? 6'(EXC_N)
                                                  : wdata[5:0];  // RULE4
      end else if (addr[11:8] == A_EXC_PAGE && addr[7:2] < 6'(EXC_N)) begin
        st_nxt.exc[addr[7:2]] = wdata[19:0];  // RULE4
      end else if (addr[11:10] == A_CAL_PAGE) begin
        if (addr[8]) begin
          st_nxt.dayt[pb][addr[7:2]] = wdata[13:0];  // RULE9
        end else if (addr[8:7] == A_WEEK_SUB) begin
          st_nxt.week[pb][addr[6:2]] = wdata[2:0];  // RULE7
        end else if (addr[6:4] == 3'h0) begin
          st_nxt.seas[pb][addr[3:2]] = wdata[11:0];  // RULE6
        end
      end
    end

    // Fault clear; a new fault in the same cycle wins
    if (wr_stb && addr == A_FAULT_CLR && wdata[0]) begin
      st_nxt.fault = 1'b0;
    end
    if (chk_bad) begin
      st_nxt.fault = 1'b1;  // RULE1
    end

    // Read mux, answered in the following cycle
    if (rd_stb) begin
      st_nxt.rdata = '0;
      if (addr == A_STATUS) begin
        st_nxt.rdata[ST_TARIFF+:3] = st_r.tariff;
        st_nxt.rdata[ST_FAULT]     = st_r.fault;
        st_nxt.rdata[ST_PEND]      = st_r.pend;
        st_nxt.rdata[ST_BANK]      = st_r.bank;
        st_nxt.rdata[ST_BUSY]      = st_r.fsm != S_IDLE;
      end else if (addr == A_LIMIT) begin
        st_nxt.rdata[15:0] = st_r.limit;
      end else if (addr == A_IRQ_STAT) begin
        st_nxt.rdata[3:0] = irq_stat;
      end else if (addr == A_IRQ_EN) begin
        st_nxt.rdata[3:0] = irq_en;
      end else if (addr == A_ACT_DATE) begin
        st_nxt.rdata[15:0] = st_r.act_date;
      end else if (addr == A_ACT_TIME) begin
        st_nxt.rdata[16:0] = st_r.act_time;
      end else if (addr == A_EXC_CNT) begin
        st_nxt.rdata[5:0] = st_r.exc_cnt;
      end else if (addr[11:8] == A_EXC_PAGE && addr[7:2] < 6'(EXC_N)) begin
        st_nxt.rdata[19:0] = st_r.exc[addr[7:2]];
      end else if (addr[11:10] == A_CAL_PAGE) begin
        if (addr[8]) begin
          st_nxt.rdata[13:0] = st_r.dayt[pb][addr[7:2]];
        end else if (addr[8:7] == A_WEEK_SUB) begin
          st_nxt.rdata[2:0] = st_r.week[pb][addr[6:2]];
        end else if (addr[6:4] == 3'h0) begin
          st_nxt.rdata[11:0] = st_r.seas[pb][addr[3:2]];
        end
      end
    end

    // Lookup sequencer, one table entry per cycle
    case (st_r.fsm)
      S_IDLE: begin
        if (tick_1s) begin
          st_nxt.fsm = S_EXC;  // RULE18
          st_nxt.idx = '0;
        end
      end
      S_EXC: begin
        if (st_r.idx < st_r.exc_cnt && ex.month == now_month &&
            ex.day == now_day &&
            (ex.pub || ex.year == now_year)) begin  // RULE3
          st_nxt.dayid = ex.dayid;  // RULE2
          st_nxt.fsm   = S_DAY;
          st_nxt.idx   = '0;
          st_nxt.le_ok = 1'b0;
          st_nxt.mx_ok = 1'b0;
        end else if (st_r.idx + 6'h01 >= st_r.exc_cnt) begin
          st_nxt.fsm   = S_SEAS;
          st_nxt.idx   = '0;
          st_nxt.le_ok = 1'b0;
          st_nxt.mx_ok = 1'b0;
        end else begin
          st_nxt.idx = st_r.idx + 6'h01;
        end
      end
      S_SEAS: begin
        key = {2'h0, se.month, se.day};
        if (se.valid && key <= now_md &&
            takes(st_r.le_ok, st_r.le_key, key)) begin  // RULE5
          st_nxt.le_ok  = 1'b1;
          st_nxt.le_key = key;
          st_nxt.le_val = {1'b0, se.weekid};
        end
        // Latest start of all covers dates before the first start
        if (se.valid && takes(st_r.mx_ok, st_r.mx_key, key)) begin
          st_nxt.mx_ok  = 1'b1;
          st_nxt.mx_key = key;
          st_nxt.mx_val = {1'b0, se.weekid};
        end
        if (st_r.idx[1:0] == 2'(SEAS_N - 1)) begin
          pick = st_nxt.le_ok ? st_nxt.le_val : st_nxt.mx_val;  // RULE6
          st_nxt.dayid = st_r.week[st_r.bank][{pick[1:0],
                                               now_wday - 3'h1}];  // RULE7
          st_nxt.fsm   = S_DAY;
          st_nxt.idx   = '0;
          st_nxt.le_ok = 1'b0;
          st_nxt.mx_ok = 1'b0;
        end else begin
          st_nxt.idx = st_r.idx + 6'h01;
        end
      end
      S_DAY: begin
        key = {de.hour, de.minute};
        if (de.valid && key <= now_hm &&
            takes(st_r.le_ok, st_r.le_key, key)) begin  // RULE18
          st_nxt.le_ok  = 1'b1;
          st_nxt.le_key = key;
          st_nxt.le_val = {1'b0, de.tcode};
        end
        // Before the first switch of the day the last one still holds
        if (de.valid && takes(st_r.mx_ok, st_r.mx_key, key)) begin
          st_nxt.mx_ok  = 1'b1;
          st_nxt.mx_key = key;
          st_nxt.mx_val = {1'b0, de.tcode};
        end
        if (st_r.idx[2:0] == 3'(DENT_N - 1)) begin
          st_nxt.fsm = S_IDLE;
          if (st_nxt.mx_ok) begin
            pick = st_nxt.le_ok ? st_nxt.le_val : st_nxt.mx_val;
            st_nxt.tariff  = pick + 3'h1;  // RULE8
            st_nxt.tar_chg = st_nxt.tariff != st_r.tariff;
          end
        end else begin
          st_nxt.idx = st_r.idx + 6'h01;
        end
      end
      default: begin
        st_nxt.fsm = S_IDLE;
      end
    endcase

    // Passive calendar takes over once its time is reached; checked
    // every cycle, so a past time after a write also fires; reset clears pend, so none after power-up
    if (st_r.pend && now_key >= {st_r.act_date, st_r.act_time}) begin
      st_nxt.bank      = ~st_r.bank;  // RULE10 RULE11 RULE12
      st_nxt.pend      = wr_stb && addr == A_ACT_TIME;  // RULE13
      st_nxt.act_pulse = 1'b1;  // RULE14
      st_nxt.fsm       = S_EXC;
      st_nxt.idx       = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Tables clear on reset, with the pending mark and activation time;
  // nothing is kept in retained storage across supply loss
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r        <= '0;
      st_r.limit  <= LIMIT_RST;
      st_r.tariff <= 3'h1;
      st_r.fsm    <= S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata       = st_r.rdata;
  assign tariff      = st_r.tariff;
  assign clock_fault = st_r.fault;
  assign act_event   = st_r.act_pulse;
endmodule
`default_nettype wire

/* sim/tariff_calendar_selector_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module tariff_calendar_selector_chk (
  input wire logic        mclk,        // System clock
  input wire logic        resetn,      // Sync reset, low
  input wire logic [11:0] addr,        // Bus address
  input wire logic [31:0] wdata,       // Bus write data
  input wire logic        wr_stb,      // Write strobe
  input wire logic        rd_stb,      // Read strobe
  input wire logic [31:0] rdata,       // Read data
  input wire logic        tick_1s,     // Second tick
  input wire logic        set_stb,     // Clock-set request
  input wire logic [2:0]  tariff,      // Active tariff
  input wire logic        clock_fault, // Fault flag
  input wire logic        act_event    // Activation pulse
);
  import tariff_pkg::*;
  logic [7:0] idle_r;  // Cycles since tick or activation
  logic       pend_r;  // Activation time armed
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////
  // Age counter saturates, so a stray tariff move long after a lookup shows
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      idle_r <= 8'hFF;
      pend_r <= 1'b0;
    end else begin
      idle_r <= (tick_1s || act_event) ? 8'h00
              : idle_r + 8'(idle_r != 8'hFF);
      pend_r <= (wr_stb && addr == A_ACT_TIME) || (pend_r && !act_event);
    end
  end
  reset_values_a: assert property (disable iff (1'b0)
    !resetn |=> tariff == 3'h1 && !clock_fault && !act_event)
    else $error("reset values wrong");
  tariff_range_a: assert property (tariff >= 3'h1 && tariff <= 3'h4)
    else $error("tariff out of range");
  tariff_timing_a: assert property (
    $changed(tariff) |-> idle_r <= 8'h50)
    else $error("tariff moved outside a lookup");
  fault_rise_a: assert property (
    $rose(clock_fault) |-> $past(set_stb, 2))
    else $error("fault without clock set");
  fault_hold_a: assert property ($fell(clock_fault) |->
    $past(wr_stb && addr == A_FAULT_CLR && wdata[0]))
    else $error("fault dropped without clear");
  act_pulse_a: assert property (act_event |=> !act_event)
    else $error("activation pulse too long");
  act_armed_a: assert property (act_event |-> $past(pend_r))
    else $error("activation without armed time");
  rdata_hold_a: assert property ($changed(rdata) |-> $past(rd_stb))
    else $error("read data moved without read");
  unmapped_rd_a: assert property (rd_stb && addr == 12'hFFC |=> rdata == 0)
    else $error("unmapped read not zero");
  cover property (tick_1s);
  cover property (act_event);
  cover property ($rose(clock_fault));
  cover property ($changed(tariff));
endmodule
`default_nettype wire

/* sim/cfg_client.sv */
`timescale 1ns/10ps
`default_nettype none
module cfg_client (
  input  wire logic        mclk,   // System clock
  output logic      [11:0] addr,   // Byte address
  output logic      [31:0] wdata,  // Write data
  output logic             wr_stb, // Write strobe
  output logic             rd_stb, // Read strobe
  input  wire logic [31:0] rdata   // Read data
);
  import tariff_pkg::*;
  // Idle bus from time zero
  initial begin
    addr = 12'hFFF;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  //////////////////////////////////////////////////
  // Released lines inverted, so stale values never pass as good
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // Data taken in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    addr <= ~a;
    @(posedge mclk);
    d = rdata;
  endtask
  // Seasons, week table 0, day table 2, in that order: season 0 from 1 Jan on week 0,
  // Saturday on day table 2, else empty 1; switches 00:00, 12:00
  task automatic cal(input logic [11:0] b, input logic [1:0] t0, t1);
    for (int i = 0; i < SEAS_N; i++)
      wr(b + 12'(4 * i), i == 0 ? 32'h0884 : 32'h0);
    for (int i = 0; i < 7; i++)
      wr(b + 12'h080 + 12'(4 * i), i == 5 ? 32'h2 : 32'h1);
    for (int i = 0; i < DENT_N; i++)
      wr(b + 12'h140 + 12'(4 * i), i == 0 ? {30'h800, t0}
         : i == 1 ? {30'hB00, t1} : 32'h0);
  endtask
  // Exception list from its count
  task automatic exc(input logic [5:0] n, input logic [31:0] e);
    wr(A_EXC_CNT, {26'h0, n});
    wr({A_EXC_PAGE, 8'h00}, e);
  endtask
  // Activation time last, after all passive parameters
  task automatic act(input logic [31:0] dt, input logic [31:0] tm);
    wr(A_ACT_DATE, dt);
    wr(A_ACT_TIME, tm);
  endtask
endmodule
`default_nettype wire

/* sim/tb_tariff_calendar_selector.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_tariff_calendar_selector;
  import tariff_pkg::*;
  logic        mclk = 0, resetn = 0, tick_1s = 0, set_stb = 0;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic        wr_stb, rd_stb, clock_fault, act_event, irq;
  logic [6:0]  year = 7'h0A;
  logic [3:0]  month = 4'h7;
  logic [4:0]  day = 5'h18, hour = 5'h0A;
  logic [5:0]  mins = 0, set_min = 0, set_sec = 0;
  logic [2:0]  tariff;
  int          bad_count = 0, checks = 0;
  // 125 MHz clock
  always #4 mclk = ~mclk;
  cfg_client i_cli (.mclk(mclk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  tariff_calendar_selector i_dut (.mclk(mclk), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .tick_1s(tick_1s), .now_year(year), .now_month(month),
    .now_day(day), .now_wday(3'h6), .now_hour(hour), .now_min(mins),
    .now_sec(6'h00), .set_stb(set_stb), .set_year(year),
    .set_month(month), .set_day(day), .set_hour(hour), .set_min(set_min),
    .set_sec(set_sec), .tariff(tariff), .clock_fault(clock_fault),
    .act_event(act_event), .irq(irq));
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, m);
    logic [31:0] d;
    i_cli.rd(a, d);
    chk(d & m, e);
  endtask
  // Lookup needs at most 63 cycles, ticks stay 70 apart
  task automatic lookup(input logic [2:0] e);
    @(posedge mclk);
    tick_1s <= 1'b1;
    @(posedge mclk);
    tick_1s <= 1'b0;
    repeat (70) @(posedge mclk);
    chk(tariff, e);
  endtask
  // Count activation pulses in a bounded window
  task automatic acts(input int n, input int e);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge mclk);
      if (act_event === 1'b1) k++;
    end
    chk(k, e);
  endtask
  task automatic pset();
    @(posedge mclk);
    set_stb <= 1'b1;
    @(posedge mclk);
    set_stb <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////
  task automatic t_reset();
    chk(tariff, 1);
    rdc(A_LIMIT, 60, 32'hFFFF);
    rdc(12'hFFC, 0, 32'hFFFF_FFFF);
    rdc(A_STATUS, 1, 32'h7F);
  endtask
  // Step of exactly the limit passes, one second more is a fault
  task automatic t_clock();
    set_min <= 6'h01;
    pset();
    chk(clock_fault, 0);
    set_sec <= 6'h01;
    pset();
    chk(clock_fault, 1);
    rdc(A_IRQ_STAT, 6, 32'hF);
    chk(irq, 0);
    i_cli.wr(A_IRQ_EN, 6);
    @(negedge mclk);
    chk(irq, 1);
    i_cli.wr(A_IRQ_CLR, 32'hF);
    i_cli.wr(A_FAULT_CLR, 1);
    @(negedge mclk);
    chk(irq, 0);
    chk(clock_fault, 0);
    i_cli.wr(A_IRQ_EN, 0);
  endtask
  task automatic t_lookup();
    i_cli.cal(12'h400, 2'h2, 2'h3);
    lookup(3);
    hour <= 5'h0C;
    mins <= 6'h1E;
    lookup(4);
    i_cli.wr(12'h5A0, 32'h2001);
    i_cli.exc(1, 32'h057C5);
    lookup(4);
    i_cli.exc(1, 32'h857C5);
    lookup(2);
    i_cli.wr(A_EXC_CNT, 63);
    rdc(A_EXC_CNT, 50, 32'h3F);
    i_cli.wr(A_EXC_CNT, 0);
    i_cli.wr(12'h404, 32'hA85);
    i_cli.wr(12'h4B4, 32'h5);
    lookup(2);
  endtask
  // Future time waits, past time fires at once, never twice
  task automatic t_act();
    i_cli.cal(12'h600, 2'h0, 2'h0);
    i_cli.act(32'h14F8, 32'hD000);
    acts(20, 0);
    @(posedge mclk);
    hour <= 5'h0D;
    acts(20, 1);
    i_cli.wr(A_IRQ_EN, 1);
    @(negedge mclk);
    chk(irq, 1);
    rdc(A_STATUS, 32'h20, 32'h30);
    lookup(1);
    i_cli.act(32'h14F8, 32'h0);
    acts(20, 1);
    lookup(2);
    acts(80, 0);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_clock();
    t_lookup();
    t_act();
    test_done();
  end
endmodule
bind tariff_calendar_selector tariff_calendar_selector_chk i_chk (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tick_1s(tick_1s),
  .set_stb(set_stb), .tariff(tariff), .clock_fault(clock_fault),
  .act_event(act_event));
`default_nettype wire
